/* File: ees_slave.sv */
// Serial memory slave: link engine, word FIFO, page buffer and program timer.
`timescale 1ns/10ps

// ==========================================================================
// Dual-clock word FIFO with gray-coded pointers.
// ==========================================================================
module ees_fifo #(
   parameter int W     = 22,
   parameter int DEPTH = 16
) (
   input  wire logic         wClk,
   input  wire logic         wRstN,
   input  wire logic         wValid,
   input  wire logic [W-1:0] wData,
   output logic              wReady,
   input  wire logic         rClk,
   input  wire logic         rRstN,
   output logic              rValid,
   output logic [W-1:0]      rData,
   input  wire logic         rReady
);
   localparam int AW = $clog2(DEPTH);

   function automatic logic [AW:0] toGray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : toGray

   logic [W-1:0] store [DEPTH];
   logic [AW:0]  wBin_r;
   logic [AW:0]  wGray_r;
   logic [AW:0]  rBin_r;
   logic [AW:0]  rGray_r;
   logic [AW:0]  rGrayS1_r;
   logic [AW:0]  rGrayS2_r;
   logic [AW:0]  wGrayS1_r;
   logic [AW:0]  wGrayS2_r;
   logic [AW:0]  wBin_nxt;
   logic [AW:0]  rBin_nxt;

   assign wReady   = wGray_r != {~rGrayS2_r[AW:AW-1], rGrayS2_r[AW-2:0]};
   assign rValid   = rGray_r != wGrayS2_r;
   assign rData    = store[rBin_r[AW-1:0]];
   assign wBin_nxt = wBin_r + {{AW{1'b0}}, 1'b1};
   assign rBin_nxt = rBin_r + {{AW{1'b0}}, 1'b1};

   always_ff @(posedge wClk) begin
      if (wValid && wReady) begin
         store[wBin_r[AW-1:0]] <= wData;
      end
   end

   always_ff @(posedge wClk or negedge wRstN) begin
      if (!wRstN) begin
         wBin_r    <= '0;
         wGray_r   <= '0;
         rGrayS1_r <= '0;
         rGrayS2_r <= '0;
      end else begin
         rGrayS1_r <= rGray_r;
         rGrayS2_r <= rGrayS1_r;
         if (wValid && wReady) begin
            wBin_r  <= wBin_nxt;
            wGray_r <= toGray(wBin_nxt);
         end
      end
   end

   always_ff @(posedge rClk or negedge rRstN) begin
      if (!rRstN) begin
         rBin_r    <= '0;
         rGray_r   <= '0;
         wGrayS1_r <= '0;
         wGrayS2_r <= '0;
      end else begin
         wGrayS1_r <= wGray_r;
         wGrayS2_r <= wGrayS1_r;
         if (rValid && rReady) begin
            rBin_r  <= rBin_nxt;
            rGray_r <= toGray(rBin_nxt);
         end
      end
   end
endmodule : ees_fifo

// ==========================================================================
// Top: link engine on linkClk, array and program timer on clk_sys.
// ==========================================================================
module ees_slave #(
   parameter int PROG_COUNT  = ees_pkg::PROG_CYC,
   parameter int PWRUP_COUNT = ees_pkg::PWRUP_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       linkClk,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       wrProtect,
   input  wire logic [2:0] busIdStrap
);
   import ees_pkg::*;

   // ======================================================================
   // Reset release, one synchroniser per domain.
   // ======================================================================
   logic sysRs1_r, rstN_r, lnkRs1_r, rstLinkN_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sysRs1_r <= 1'b0;
         rstN_r   <= 1'b0;
      end else begin
         sysRs1_r <= 1'b1;
         rstN_r   <= sysRs1_r;
      end
   end

   always_ff @(posedge linkClk or negedge arst_n) begin
      if (!arst_n) begin
         lnkRs1_r   <= 1'b0;
         rstLinkN_r <= 1'b0;
      end else begin
         lnkRs1_r   <= 1'b1;
         rstLinkN_r <= lnkRs1_r;
      end
   end

   // ======================================================================
   // Pin synchronisers and glitch filters on the link clock.
   // ======================================================================
   // Undriven strap and protect pins are pulled low outside, so reset is low.
   logic [5:0] pinS1_r, pinS2_r;
   logic       sclF_r, sdaF_r, sclP_r, sdaP_r;
   logic [1:0] sclCnt_r, sdaCnt_r;
   logic       busyS1_r, busyS2_r, rspS1_r, rspS2_r, rspS3_r;
   logic       sclS, sdaS, wpS;
   logic [2:0] strapS;

   assign {sclS, sdaS, wpS, strapS} = pinS2_r;

   always_ff @(posedge linkClk or negedge rstLinkN_r) begin
      if (!rstLinkN_r) begin
         pinS1_r <= 6'h30;
         pinS2_r <= 6'h30;
      end else begin
         pinS1_r <= {sclIn, sdaIn, wrProtect, busIdStrap};
         pinS2_r <= pinS1_r;
      end
   end

   // A level change is taken only after it has held for GLITCH_CYC samples,
   // which at 48 ns per sample outlasts any 50 ns pulse.
   always_ff @(posedge linkClk or negedge rstLinkN_r) begin
      if (!rstLinkN_r) begin
         sclF_r   <= 1'b1;
         sdaF_r   <= 1'b1;
         sclP_r   <= 1'b1;
         sdaP_r   <= 1'b1;
         sclCnt_r <= 2'h0;
         sdaCnt_r <= 2'h0;
      end else begin
         sclP_r   <= sclF_r;
         sdaP_r   <= sdaF_r;
         sclCnt_r <= (sclS != sclF_r) ? sclCnt_r + 2'h1 : 2'h0;
         sdaCnt_r <= (sdaS != sdaF_r) ? sdaCnt_r + 2'h1 : 2'h0;
         if (sclS != sclF_r && sclCnt_r == 2'(GLITCH_CYC - 1)) begin
            sclF_r   <= sclS;
            sclCnt_r <= 2'h0;
         end
         if (sdaS != sdaF_r && sdaCnt_r == 2'(GLITCH_CYC - 1)) begin
            sdaF_r   <= sdaS;
            sdaCnt_r <= 2'h0;
         end
      end
   end

   // ======================================================================
   // Link engine.
   // ======================================================================
   ees_link_st_t       st_r, nxt_r;
   logic [3:0]         bitCnt_r;
   logic [7:0]         sh_r, rdData_r, rdByte_r;
   logic               inAck_r, ackPend_r, ackGo_r, mAck_r, wpBlock_r, wrAny_r;
   logic [ADDR_W-1:0]  wordAddr_r, fetchAddr_r;
   logic               fetchTgl_r, pushV_r;
   logic [WORD_W-1:0]  pushData_r;
   logic               fifoWReady, rspTgl_r, busyLvl_r;
   logic [7:0]         byteIn;
   logic [2:0]         txIdx;
   logic               sclRise, sclFall, startEv, stopEv, loadNow, rxSt;

   assign byteIn  = {sh_r[6:0], sdaF_r};
   assign txIdx   = 3'(4'd7 - bitCnt_r);
   assign sclRise = sclF_r && !sclP_r;
   assign sclFall = !sclF_r && sclP_r;
   assign startEv = sclF_r && sclP_r && sdaP_r && !sdaF_r;
   assign stopEv  = sclF_r && sclP_r && !sdaP_r && sdaF_r;
   assign rxSt    = (st_r == ST_DEV) || (st_r == ST_AHI) || (st_r == ST_ALO) || (st_r == ST_WDAT);
   assign loadNow = sclFall && !ackPend_r
                    && ((inAck_r && nxt_r == ST_RDAT) || (!inAck_r && st_r == ST_RACK && mAck_r));
   // Open drain: the line is only ever pulled low, so the data level stays zero.
   always_ff @(posedge linkClk or negedge rstLinkN_r) begin
      if (!rstLinkN_r) begin
         sdaOut   <= 1'b0;
         busyS1_r <= 1'b1;
         busyS2_r <= 1'b1;
         rspS1_r  <= 1'b0;
         rspS2_r  <= 1'b0;
         rspS3_r  <= 1'b0;
         rdData_r <= 8'hFF;
      end else begin
         sdaOut   <= 1'b0;
         busyS1_r <= busyLvl_r;
         busyS2_r <= busyS1_r;
         rspS1_r  <= rspTgl_r;
         rspS2_r  <= rspS1_r;
         rspS3_r  <= rspS2_r;
         if (rspS2_r != rspS3_r) begin
            rdData_r <= rdByte_r;
         end
      end
   end

   always_ff @(posedge linkClk or negedge rstLinkN_r) begin
      if (!rstLinkN_r) begin
         st_r        <= ST_IDLE;
         nxt_r       <= ST_IDLE;
         bitCnt_r    <= 4'h0;
         sh_r        <= 8'h00;
         inAck_r     <= 1'b0;
         ackPend_r   <= 1'b0;
         ackGo_r     <= 1'b0;
         mAck_r      <= 1'b0;
         wpBlock_r   <= 1'b0;
         wrAny_r     <= 1'b0;
         wordAddr_r  <= '0;
         fetchAddr_r <= '0;
         fetchTgl_r  <= 1'b0;
         pushV_r     <= 1'b0;
         pushData_r  <= '0;
         sdaOe       <= 1'b0;
      end else begin
         pushV_r <= 1'b0;
         if (startEv) begin
            st_r      <= ST_DEV;
            bitCnt_r  <= 4'h0;
            inAck_r   <= 1'b0;
            ackPend_r <= 1'b0;
            sdaOe     <= 1'b0;
         end else if (stopEv) begin
            if (wrAny_r) begin
               pushV_r    <= 1'b1;
               pushData_r <= {1'b1, {(WORD_W-1){1'b0}}};
            end
            wrAny_r   <= 1'b0;
            st_r      <= ST_IDLE;
            inAck_r   <= 1'b0;
            ackPend_r <= 1'b0;
            sdaOe     <= 1'b0;
         end else if (sclRise) begin
            if (rxSt && !inAck_r) begin
               sh_r     <= byteIn;
               bitCnt_r <= bitCnt_r + 4'h1;
               if (bitCnt_r == 4'd7) begin
                  ackPend_r <= 1'b1;
                  case (st_r)
                     ST_DEV: begin
                        if (byteIn[7:4] == DEV_TYPE && byteIn[3:1] == strapS && !busyS2_r) begin
                           ackGo_r <= 1'b1;
                           nxt_r   <= byteIn[0] ? ST_RDAT : ST_AHI;
                           if (byteIn[0]) begin
                              fetchAddr_r <= wordAddr_r;
                              fetchTgl_r  <= !fetchTgl_r;
                           end
                        end else begin
                           ackGo_r <= 1'b0;
                           nxt_r   <= ST_WAIT;
                        end
                     end
                     ST_AHI: begin
                        ackGo_r                   <= 1'b1;
                        nxt_r                     <= ST_ALO;
                        wordAddr_r[ADDR_W-1:8]    <= byteIn[ADDR_W-9:0];
                     end
                     ST_ALO: begin
                        ackGo_r          <= 1'b1;
                        nxt_r            <= ST_WDAT;
                        wordAddr_r[7:0]  <= byteIn;
                     end
                     default: begin
                        // Data byte: protect refuses it, a full FIFO refuses it too.
                        if (!wpBlock_r && fifoWReady) begin
                           ackGo_r    <= 1'b1;
                           nxt_r      <= ST_WDAT;
                           wrAny_r    <= 1'b1;
                           pushV_r    <= 1'b1;
                           pushData_r <= {1'b0, wordAddr_r, byteIn};
                           wordAddr_r <= {wordAddr_r[ADDR_W-1:OFS_W], wordAddr_r[OFS_W-1:0] + 5'h01};
                        end else begin
                           ackGo_r <= 1'b0;
                           nxt_r   <= ST_WAIT;
                        end
                     end
                  endcase
               end
            end else if (st_r == ST_RDAT) begin
               bitCnt_r <= bitCnt_r + 4'h1;
            end else if (st_r == ST_RACK) begin
               mAck_r <= !sdaF_r;
            end
         end else if (sclFall) begin
            if (loadNow) begin
               // Current byte goes out; the next one is fetched meanwhile.
               st_r        <= ST_RDAT;
               inAck_r     <= 1'b0;
               bitCnt_r    <= 4'h0;
               sh_r        <= rdData_r;
               sdaOe       <= !rdData_r[7];
               wordAddr_r  <= wordAddr_r + 13'h0001;
               fetchAddr_r <= wordAddr_r + 13'h0001;
               fetchTgl_r  <= !fetchTgl_r;
            end else if (ackPend_r) begin
               ackPend_r <= 1'b0;
               inAck_r   <= 1'b1;
               sdaOe     <= ackGo_r;
            end else if (inAck_r) begin
               inAck_r  <= 1'b0;
               sdaOe    <= 1'b0;
               bitCnt_r <= 4'h0;
               st_r     <= nxt_r;
               if (st_r == ST_ALO) begin
                  wpBlock_r <= wpS;
               end
            end else if (st_r == ST_RDAT) begin
               if (bitCnt_r == 4'd8) begin
                  sdaOe <= 1'b0;
                  st_r  <= ST_RACK;
               end else begin
                  sdaOe <= !sh_r[txIdx];
               end
            end else if (st_r == ST_RACK) begin
               st_r <= ST_WAIT;
            end
         end
      end
   end

   // ======================================================================
   // Word FIFO into the system domain.
   // ======================================================================
   logic              popV, popReady;
   logic [WORD_W-1:0] popData;

   ees_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .wClk   (linkClk),
      .wRstN  (rstLinkN_r),
      .wValid (pushV_r),
      .wData  (pushData_r),
      .wReady (fifoWReady),
      .rClk   (clk_sys),
      .rRstN  (rstN_r),
      .rValid (popV),
      .rData  (popData),
      .rReady (popReady)
   );

   // ======================================================================
   // System domain: power-up delay, read port, page buffer, program cycle.
   // ======================================================================
   logic [7:0]            mem  [MEM_BYTES];
   logic [7:0]            pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask_r;
   logic [7:0]            page_r;
   logic                  progBusy_r, ready_r;
   logic [16:0]           progCnt_r;
   logic [12:0]           pwrCnt_r;
   logic [5:0]            cpIdx_r;
   logic                  fTgS1_r, fTgS2_r, fTgS3_r;
   logic                  popTake;

   // The drain stalls while programming, so the FIFO can truly fill.
   assign popReady = !progBusy_r;
   assign popTake  = popV && popReady;

   always_ff @(posedge clk_sys or negedge rstN_r) begin
      if (!rstN_r) begin
         pwrCnt_r  <= 13'h0000;
         ready_r   <= 1'b0;
         busyLvl_r <= 1'b1;
      end else begin
         if (!ready_r) begin
            pwrCnt_r <= pwrCnt_r + 13'h0001;
            ready_r  <= pwrCnt_r == 13'(PWRUP_COUNT - 1);
         end
         busyLvl_r <= progBusy_r || !ready_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN_r) begin
      if (!rstN_r) begin
         fTgS1_r  <= 1'b0;
         fTgS2_r  <= 1'b0;
         fTgS3_r  <= 1'b0;
         rspTgl_r <= 1'b0;
         rdByte_r <= 8'hFF;
      end else begin
         fTgS1_r <= fetchTgl_r;
         fTgS2_r <= fTgS1_r;
         fTgS3_r <= fTgS2_r;
         // The address was set with its toggle and holds until the next one.
         if (fTgS2_r != fTgS3_r) begin
            rdByte_r <= mem[fetchAddr_r];
            rspTgl_r <= !rspTgl_r;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (popTake && !popData[W_COMMIT]) begin
         pbuf[popData[W_ADDR_LO+OFS_W-1:W_ADDR_LO]] <= popData[BYTE_LAST:0];
      end
      if (progBusy_r && !cpIdx_r[5] && mask_r[cpIdx_r[4:0]]) begin
         mem[{page_r, cpIdx_r[4:0]}] <= pbuf[cpIdx_r[4:0]];
      end
   end

   always_ff @(posedge clk_sys or negedge rstN_r) begin
      if (!rstN_r) begin
         mask_r     <= '0;
         page_r     <= 8'h00;
         progBusy_r <= 1'b0;
         progCnt_r  <= 17'h00000;
         cpIdx_r    <= 6'h00;
      end else if (progBusy_r) begin
         if (!cpIdx_r[5]) begin
            cpIdx_r <= cpIdx_r + 6'h01;
         end
         progCnt_r <= progCnt_r + 17'h00001;
         if (progCnt_r == 17'(PROG_COUNT - 1)) begin
            progBusy_r <= 1'b0;
            mask_r     <= '0;
         end
      end else if (popTake) begin
         if (popData[W_COMMIT]) begin
            if (mask_r != '0) begin
               progBusy_r <= 1'b1;
               progCnt_r  <= 17'h00000;
               cpIdx_r    <= 6'h00;
            end
         end else begin
            page_r <= popData[W_ADDR_HI:W_ADDR_LO+OFS_W];
            mask_r[popData[W_ADDR_LO+OFS_W-1:W_ADDR_LO]] <= 1'b1;
         end
      end
   end

   // ======================================================================
   // Checks.
   // ======================================================================
   sequence lastBitIn;
      sclRise && rxSt && !inAck_r && bitCnt_r == 4'd7 && !startEv && !stopEv;
   endsequence

   sequence ackDriven;
      sclFall && ackPend_r && !loadNow ##1 inAck_r;
   endsequence

   dev_match_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      (lastBitIn and (st_r == ST_DEV && byteIn[7:4] != DEV_TYPE)) |=> !ackGo_r && nxt_r == ST_WAIT)
      else $error("foreign device type acknowledged");

   strap_id_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      (lastBitIn and (st_r == ST_DEV && byteIn[3:1] != strapS)) |=> !ackGo_r)
      else $error("address with other strap bits acknowledged");

   busy_nack_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      (lastBitIn and (st_r == ST_DEV && busyS2_r)) |=> !ackGo_r)
      else $error("acknowledge given while busy");

   ack_drive_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      ackDriven |-> sdaOe == ackGo_r)
      else $error("acknowledge level differs from decision");

   wp_reject_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      (lastBitIn and (st_r == ST_WDAT && wpBlock_r)) |=> !pushV_r && !ackGo_r)
      else $error("protected write byte accepted");

   page_wrap_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      pushV_r && !pushData_r[W_COMMIT]
      |-> wordAddr_r == {pushData_r[W_ADDR_HI:W_ADDR_LO+OFS_W], pushData_r[W_ADDR_LO+OFS_W-1:W_ADDR_LO] + 5'h01})
      else $error("page offset did not wrap within page");

   seq_read_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      loadNow && !startEv && !stopEv |=> wordAddr_r == $past(wordAddr_r) + 13'h0001 && st_r == ST_RDAT)
      else $error("read address did not advance");

   scl_filter_a : assert property (@(posedge linkClk) disable iff (!rstLinkN_r)
      $changed(sclF_r) |-> $past(sclS, 1) == sclF_r && $past(sclS, 2) == sclF_r && $past(sclS, 3) == sclF_r)
      else $error("short pulse reached the clock filter output");

   prog_time_a : assert property (@(posedge clk_sys) disable iff (!rstN_r)
      $fell(progBusy_r) |-> $past(progCnt_r) == 17'(PROG_COUNT - 1))
      else $error("program cycle length wrong");

   commit_a : assert property (@(posedge clk_sys) disable iff (!rstN_r)
      popTake && popData[W_COMMIT] && mask_r != '0 |=> progBusy_r [*2])
      else $error("commit did not start program cycle");

   pwrup_a : assert property (@(posedge clk_sys) disable iff (!rstN_r)
      $rose(ready_r) |-> $past(pwrCnt_r) == 13'(PWRUP_COUNT - 1) ##2 !busyLvl_r || progBusy_r)
      else $error("power-up delay wrong");
endmodule : ees_slave

/* File: ees_pkg.sv */
// Constants, types and timing counts shared by the serial memory slave.
// Functional notes
// - Array holds 256 pages of 32 bytes, 8192 byte locations in all.
// - A write gives a start address then 1 to 32 bytes, committed together.
// - Reads shift out bytes from the start address, advancing after each byte.
// - Three strap pins set the bus identity; only that address is answered.
// - Works at serial clock rates up to 100 kHz, 400 kHz and 1 MHz.
// - Each internal program cycle finishes within 4 ms of its start.
// - Device accepts bus commands within 0.35 ms after power becomes stable.
// - Write-protect high blocks writes to every array location.
// - Pulses of 50 ns or less on clock and data inputs are ignored.
// - Write-protect and strap inputs read low when left unconnected.
// - Address byte must be 1010, then strap bits; last bit 1 reads, 0 writes.
// - No acknowledge while programming; master repeats until acknowledged.
// - Write-protect high before first data byte: byte refused, write rejected.
// - Page load keeps page latched, offset wraps within page.
package ees_pkg;
   localparam int          PAGES        = 256;
   localparam int          PAGE_BYTES   = 32;
   localparam int          MEM_BYTES    = PAGES * PAGE_BYTES;
   localparam int          ADDR_W       = 13;
   localparam int          OFS_W        = 5;
   localparam logic [3:0]  DEV_TYPE     = 4'hA;
   localparam int          SCL_STD_KHZ  = 100;
   localparam int          SCL_FAST_KHZ = 400;
   localparam int          SCL_FPLS_KHZ = 1000;
   localparam int          SYS_CLK_NS   = 50;
   localparam int          LINK_CLK_NS  = 48;
   localparam int          PROG_TIME_NS = 4000000;
   localparam int          PROG_CYC     = PROG_TIME_NS / SYS_CLK_NS;
   localparam int          PWRUP_NS     = 350000;
   localparam int          PWRUP_CYC    = PWRUP_NS / SYS_CLK_NS;
   localparam int          GLITCH_NS    = 50;
   localparam int          GLITCH_CYC   = (GLITCH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS + 1;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          WORD_W       = 22;
   localparam int          W_COMMIT     = 21;
   localparam int          W_ADDR_HI    = 20;
   localparam int          W_ADDR_LO    = 8;
   localparam int          BYTE_LAST    = 7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV  = 3'b001,
      ST_AHI  = 3'b010,
      ST_ALO  = 3'b011,
      ST_WDAT = 3'b100,
      ST_RDAT = 3'b101,
      ST_RACK = 3'b110,
      ST_WAIT = 3'b111
   } ees_link_st_t;
endpackage : ees_pkg

/* File: ees_master_model.sv */
// Bus master model: drives the serial clock and shares the open-drain data line.
`timescale 1ns/10ps
module ees_master_model (
   input  wire logic clk_sys,
   input  wire logic sdaOe,
   output logic      sclIn,
   output logic      sdaIn
);
   logic mOe = 1'b0;
   initial sclIn = 1'b1;
   // Pull-up wins whenever neither side pulls the line low.
   assign sdaIn = !(sdaOe | mOe);
   task automatic drv(input logic c, input logic o, input int n);
      sclIn = c;
      mOe = o;
      repeat (n) @(negedge clk_sys);
   endtask : drv
   // A bit lasts 20 cycles, 1 MHz, so the 1 MHz mode's rate is not exceeded.
   task automatic xbit(input logic d, output logic s);
      drv(1'b0, !d, 5);
      drv(1'b1, !d, 5);
      s = sdaIn;
      drv(1'b1, !d, 5);
      drv(1'b0, !d, 5);
   endtask : xbit
   // Also serves as repeated start.
   task automatic start();
      drv(1'b0, 1'b0, 5);
      drv(1'b1, 1'b0, 10);
      drv(1'b1, 1'b1, 10);
      drv(1'b0, 1'b1, 5);
   endtask : start
   task automatic stop();
      drv(1'b0, 1'b1, 5);
      drv(1'b1, 1'b1, 10);
      drv(1'b1, 1'b0, 10);
   endtask : stop
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xbit(b[i], s);
         r[i] = s;
      end
      xbit(last, s);
      ack = !s;
   endtask : xfer
endmodule : ees_master_model

/* File: tb_top.sv */
// Testbench for the serial memory slave.
`timescale 1ns/10ps
module tb_top;
   import ees_pkg::*;
   typedef struct {logic [12:0] a; logic [7:0] d;} ees_row_t;
   localparam logic [2:0] STRAP = 3'h5;
   logic       clk_sys = 1'b0;
   logic       linkClk = 1'b0;
   logic       arst_n = 1'b0;
   logic       wrProtect = 1'b0;
   logic       sclIn, sdaIn, sdaOut, sdaOe, ack;
   logic [7:0] q0, q1;
   logic [7:0] bad[2] = '{{DEV_TYPE, STRAP ^ 3'h1, 1'b0}, {4'hB, STRAP, 1'b0}};
   int         errorCnt = 0;
   int         checksDone = 0;
   int         n;
   ees_row_t   rows[3] = '{'{13'h1FFF, 8'h5A}, '{13'h0000, 8'hC3}, '{13'h0ABC, 8'h81}};
   ees_slave #(.PROG_COUNT(400), .PWRUP_COUNT(40)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
      .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .wrProtect(wrProtect), .busIdStrap(STRAP));
   ees_master_model mst_u (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   initial forever #25 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #24 linkClk = ~linkClk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] b, output logic k);
      logic [7:0] r;
      mst_u.xfer(b, 1'b1, r, k);
   endtask : send
   task automatic setAddr(input logic [12:0] a);
      logic k1, k2;
      mst_u.start();
      send({DEV_TYPE, STRAP, 1'b0}, ack);
      send({3'h0, a[12:8]}, k1);
      send(a[7:0], k2);
      ack = ack & k1 & k2;
   endtask : setAddr
   // Bounded so a device that never answers cannot hang the run.
   task automatic poll();
      n = 0;
      do begin
         mst_u.start();
         send({DEV_TYPE, STRAP, 1'b0}, ack);
         mst_u.stop();
         n++;
      end while (!ack && n < 40);
   endtask : poll
   task automatic rd(input logic [12:0] a);
      logic k;
      setAddr(a);
      mst_u.start();
      send({DEV_TYPE, STRAP, 1'b1}, k);
      mst_u.xfer(8'hFF, 1'b0, q0, k);
      mst_u.xfer(8'hFF, 1'b1, q1, k);
      mst_u.stop();
   endtask : rd
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrapUp
   initial begin
      repeat (40000) @(posedge clk_sys);
      errorCnt++;
      wrapUp();
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (60) @(negedge clk_sys);
      poll();
      check(8'(n), 8'h01);
      $display("power-up test done");
      foreach (rows[i]) begin
         setAddr(rows[i].a);
         send(rows[i].d, ack);
         mst_u.stop();
         poll();
         check({7'h0, n > 1}, 8'h01);
         check({7'h0, n < 40}, 8'h01);
         check({7'h0, sdaOut}, 8'h00);
         rd(rows[i].a);
         check(q0, rows[i].d);
      end
      rd(13'h1FFF);
      check(q1, rows[1].d);
      $display("row test done");
      foreach (bad[i]) begin
         mst_u.start();
         send(bad[i], ack);
         mst_u.stop();
         check({7'h0, ack}, 8'h00);
      end
      wrProtect = 1'b1;
      setAddr(rows[2].a);
      send(8'h00, ack);
      mst_u.stop();
      check({7'h0, ack}, 8'h00);
      wrProtect = 1'b0;
      rd(rows[2].a);
      check(q0, rows[2].d);
      $display("refusal test done");
      setAddr(13'h0040);
      for (int i = 0; i < 33; i++) send(8'(i), ack);
      mst_u.stop();
      poll();
      rd(13'h0040);
      check(q0, 8'h20);
      check(q1, 8'h01);
      $display("page test done");
      wrapUp();
   end
endmodule : tb_top
